// ==== uepc_endpoint.sv ====
// Endpoint 1-3 IN/OUT control and status logic with a classic Wishbone slave
//
// What this block does
// - IN FIFO flag reads 0 when empty, 1 with one or more packets.
// - Clear in_packet_ready on transmit, or with double buffering and a free slot.
// - Isochronous with underrun mode: in_packet_ready reads 0 until next SOF.
// - Transmit-caused clear of in_packet_ready raises the IN interrupt if enabled.
// - IN high bit 7 turns IN double buffering off or on.
// - IN high bit 6 selects bulk/interrupt or isochronous.
// - Bit 5 selects OUT or IN, only while split is 0.
// - Bit 3: toggle flips on ACK, or after every sent packet when 1.
// - Split bit 2: upper FIFO half to IN, lower half to OUT.
// - OUT interrupt when hardware sets out_packet_ready or sends a STALL.
// - Bulk OUT packet received sets out_packet_ready and interrupts.
// - Byte count of the ready OUT packet sits in high and low registers.
// - While out_send_stall is 1, every bulk OUT gets a STALL.
// - Each STALL sets out_stall_sent and interrupts; firmware clears it.
// - Two OUT packets held: out_packet_ready sets again after clear, second interrupt.
// - OUT high bit 6 selects isochronous OUT mode.
// - Isochronous packet with no room interrupts and sets out_overrun.
// - Isochronous CRC error still loads, sets ready and out_crc_error.
// - IN high bits 1 and 0 read zero, writes ignored.
// - Writing 1 to OUT clear_toggle zeroes the OUT toggle; bit reads 0.
`timescale 1ns/1ns
`default_nettype none

module uepc_endpoint (
    input  wire logic                   CLK_I,
    input  wire logic                   RST_I,
    input  wire logic                   CYC_I,
    input  wire logic                   STB_I,
    input  wire logic                   WE_I,
    input  wire logic [7:0]             ADR_I,
    input  wire logic [3:0]             SEL_I,
    input  wire logic [31:0]            DAT_I,
    output logic      [31:0]            DAT_O,
    output logic                        ACK_O,
    input  wire uepc_pkg::uepc_link_in_s  LINK_I,
    output var uepc_pkg::uepc_link_out_s  LINK_O,
    output logic                        IN_INT_O,
    output logic                        OUT_INT_O
);

    uepc_pkg::uepc_state_s q_r;
    uepc_pkg::uepc_state_s q_nxt;

    logic [5:0]  idx;
    logic [7:0]  wd;
    logic        req;
    logic        wr;
    logic        wr_in_low;
    logic        wr_in_high;
    logic        wr_out_low;
    logic        wr_out_high;
    logic        wr_mode;
    logic        out_pop;
    logic        out_room;
    logic [1:0]  in_cap;
    logic [1:0]  out_cap;
    logic [15:0] cnt_wide;
    logic [7:0]  rd_val;

    assign idx         = ADR_I[7:2];
    assign wd          = DAT_I[7:0];
    assign req         = CYC_I && STB_I;
    // Write lands only on the edge where ack is already high
    assign wr          = req && WE_I && q_r.wb_ack && SEL_I[0];
    assign wr_in_low   = wr && (idx == uepc_pkg::IDX_IN_CTL_LOW);
    assign wr_in_high  = wr && (idx == uepc_pkg::IDX_IN_CTL_HIGH);
    assign wr_out_low  = wr && (idx == uepc_pkg::IDX_OUT_CTL_LOW);
    assign wr_out_high = wr && (idx == uepc_pkg::IDX_OUT_CTL_HIGH);
    assign wr_mode     = wr && (idx == uepc_pkg::IDX_EP_MODE);
    assign in_cap      = q_r.in_dbl  ? uepc_pkg::SLOTS_DOUBLE : uepc_pkg::SLOTS_SINGLE;
    assign out_cap     = q_r.out_dbl ? uepc_pkg::SLOTS_DOUBLE : uepc_pkg::SLOTS_SINGLE;
    assign cnt_wide    = 16'(q_r.out_cnt0);

    // Firmware releases the head OUT packet by clearing ready or flushing
    assign out_pop = wr_out_low && (q_r.out_slots != 2'h0) &&
                     ((q_r.out_opr && !wd[uepc_pkg::B_OUT_OPR]) || wd[uepc_pkg::B_OUT_FLUSH]);

    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            uepc_pkg::IDX_IN_CTL_LOW: begin
                rd_val[uepc_pkg::B_IN_PRDY]    = q_r.in_prdy && !q_r.in_iso_wait;
                rd_val[uepc_pkg::B_IN_HAS_PKT] = q_r.in_slots != 2'h0;
            end
            uepc_pkg::IDX_IN_CTL_HIGH: begin
                rd_val[uepc_pkg::B_IN_DBL]   = q_r.in_dbl;
                rd_val[uepc_pkg::B_IN_ISO]   = q_r.in_iso;
                rd_val[uepc_pkg::B_IN_DIR]   = q_r.in_dir;
                rd_val[uepc_pkg::B_IN_FORCE] = q_r.in_force;
                rd_val[uepc_pkg::B_IN_SPLIT] = q_r.in_split;
            end
            uepc_pkg::IDX_OUT_CTL_LOW: begin
                rd_val[uepc_pkg::B_OUT_OPR]      = q_r.out_opr;
                rd_val[uepc_pkg::B_OUT_FULL]     = q_r.out_slots == out_cap;
                rd_val[uepc_pkg::B_OUT_OVR]      = q_r.out_overrun;
                rd_val[uepc_pkg::B_OUT_CRC]      = q_r.out_crc_err;
                rd_val[uepc_pkg::B_OUT_SEND_STL] = q_r.out_send_stall;
                rd_val[uepc_pkg::B_OUT_STL_SENT] = q_r.out_stall_sent;
            end
            uepc_pkg::IDX_OUT_CTL_HIGH: begin
                rd_val[uepc_pkg::B_OUT_DBL] = q_r.out_dbl;
                rd_val[uepc_pkg::B_OUT_ISO] = q_r.out_iso;
            end
            uepc_pkg::IDX_OUT_CNT_LOW:  rd_val = cnt_wide[7:0];
            uepc_pkg::IDX_OUT_CNT_HIGH: rd_val = cnt_wide[15:8];
            uepc_pkg::IDX_EP_MODE: begin
                rd_val[uepc_pkg::B_IN_INT_EN]   = q_r.in_int_en;
                rd_val[uepc_pkg::B_OUT_INT_EN]  = q_r.out_int_en;
                rd_val[uepc_pkg::B_IN_UNDERRUN] = q_r.in_ud;
            end
            default: rd_val = 8'h00;
        endcase
    end

    always_comb begin
        q_nxt          = q_r;
        q_nxt.hs_ack   = 1'b0;
        q_nxt.hs_nak   = 1'b0;
        q_nxt.hs_stall = 1'b0;
        q_nxt.in_int   = 1'b0;
        q_nxt.out_int  = 1'b0;
        q_nxt.wb_ack   = req && !q_r.wb_ack;
        if (req && !q_r.wb_ack) begin
            q_nxt.wb_dat = rd_val;
        end

        // Configuration writes
        if (wr_in_high) begin
            q_nxt.in_dbl   = wd[uepc_pkg::B_IN_DBL];
            q_nxt.in_iso   = wd[uepc_pkg::B_IN_ISO];
            q_nxt.in_dir   = wd[uepc_pkg::B_IN_DIR];
            q_nxt.in_force = wd[uepc_pkg::B_IN_FORCE];
            q_nxt.in_split = wd[uepc_pkg::B_IN_SPLIT];
        end
        if (wr_out_high) begin
            q_nxt.out_dbl = wd[uepc_pkg::B_OUT_DBL];
            q_nxt.out_iso = wd[uepc_pkg::B_OUT_ISO];
        end
        if (wr_mode) begin
            q_nxt.in_int_en  = wd[uepc_pkg::B_IN_INT_EN];
            q_nxt.out_int_en = wd[uepc_pkg::B_OUT_INT_EN];
            q_nxt.in_ud      = wd[uepc_pkg::B_IN_UNDERRUN];
        end

        // IN side: transmit completion frees the oldest slot
        if (LINK_I.in_tx_done && q_r.in_slots != 2'h0) begin
            q_nxt.in_slots = q_r.in_slots - 2'h1;
            q_nxt.in_prdy  = 1'b0;
            q_nxt.in_int   = q_r.in_int_en;
        end
        if (q_r.in_force ? LINK_I.in_tx_done : LINK_I.in_ack) begin
            q_nxt.in_toggle = !q_r.in_toggle;
        end
        if (LINK_I.sof) begin
            q_nxt.in_iso_wait = 1'b0;
        end
        if (wr_in_low) begin
            // Load is refused while ready is still high or no slot is free
            if (wd[uepc_pkg::B_IN_PRDY] && !q_r.in_prdy && q_nxt.in_slots < in_cap) begin
                q_nxt.in_prdy  = 1'b1;
                q_nxt.in_slots = q_nxt.in_slots + 2'h1;
                if (q_r.in_iso && q_r.in_ud) begin
                    q_nxt.in_iso_wait = 1'b1;
                end
            end
            if (wd[uepc_pkg::B_IN_FLUSH] && q_nxt.in_slots != 2'h0) begin
                q_nxt.in_slots = q_nxt.in_slots - 2'h1;
                q_nxt.in_prdy  = 1'b0;
            end
            if (wd[uepc_pkg::B_IN_CLR_TOG]) begin
                q_nxt.in_toggle = 1'b0;
            end
        end
        // Second slot still open: hand ready back so firmware can load again
        if (q_r.in_dbl && q_r.in_prdy && q_r.in_slots < uepc_pkg::SLOTS_DOUBLE) begin
            q_nxt.in_prdy = 1'b0;
        end

        // OUT side firmware writes come first so hardware sets win
        if (wr_out_low) begin
            q_nxt.out_send_stall = wd[uepc_pkg::B_OUT_SEND_STL];
            if (!wd[uepc_pkg::B_OUT_STL_SENT]) begin
                q_nxt.out_stall_sent = 1'b0;
            end
            if (!wd[uepc_pkg::B_OUT_OVR]) begin
                q_nxt.out_overrun = 1'b0;
            end
            if (wd[uepc_pkg::B_OUT_CLR_TOG]) begin
                q_nxt.out_toggle = 1'b0;
            end
        end
        if (out_pop) begin
            q_nxt.out_cnt0    = q_r.out_cnt1;
            q_nxt.out_slots   = q_r.out_slots - 2'h1;
            q_nxt.out_opr     = 1'b0;
            q_nxt.out_crc_err = 1'b0;
        end
        out_room = q_nxt.out_slots < out_cap;

        if (LINK_I.out_pkt) begin
            if (!q_r.out_iso) begin
                if (q_r.out_send_stall) begin
                    q_nxt.hs_stall       = 1'b1;
                    q_nxt.out_stall_sent = 1'b1;
                    q_nxt.out_int        = q_r.out_int_en;
                end else if (LINK_I.out_crc_err) begin
                    // Corrupt bulk packet: no handshake, host retries
                    q_nxt.out_slots = q_nxt.out_slots;
                end else if (out_room) begin
                    q_nxt.hs_ack     = 1'b1;
                    q_nxt.out_toggle = !q_r.out_toggle;
                    if (q_nxt.out_slots == 2'h0) begin
                        q_nxt.out_cnt0 = LINK_I.out_bytes;
                    end else begin
                        q_nxt.out_cnt1 = LINK_I.out_bytes;
                    end
                    q_nxt.out_slots = q_nxt.out_slots + 2'h1;
                end else begin
                    q_nxt.hs_nak = 1'b1;
                end
            end else if (out_room) begin
                if (q_nxt.out_slots == 2'h0) begin
                    q_nxt.out_cnt0 = LINK_I.out_bytes;
                end else begin
                    q_nxt.out_cnt1 = LINK_I.out_bytes;
                end
                q_nxt.out_slots = q_nxt.out_slots + 2'h1;
                if (LINK_I.out_crc_err) begin
                    // Flag is shared, so the ready head shows it even when the packet lands in the second slot
                    q_nxt.out_crc_err = 1'b1;
                end
            end else begin
                q_nxt.out_overrun = 1'b1;
                q_nxt.out_int     = q_r.out_int_en;
            end
        end

        // Ready rises one cycle after a slot holds a packet, also after a release
        if (!q_r.out_opr && q_r.out_slots != 2'h0 && !out_pop) begin
            q_nxt.out_opr = 1'b1;
            q_nxt.out_int = q_r.out_int_en;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            q_r <= uepc_pkg::UEPC_STATE_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign ACK_O                 = q_r.wb_ack;
    assign DAT_O                 = {24'h000000, q_r.wb_dat};
    assign IN_INT_O              = q_r.in_int;
    assign OUT_INT_O             = q_r.out_int;
    assign LINK_O.in_pkt_avail   = (q_r.in_slots != 2'h0) && !q_r.in_iso_wait;
    assign LINK_O.in_toggle      = q_r.in_toggle;
    assign LINK_O.out_toggle     = q_r.out_toggle;
    assign LINK_O.out_ack        = q_r.hs_ack;
    assign LINK_O.out_nak        = q_r.hs_nak;
    assign LINK_O.out_stall      = q_r.hs_stall;
    assign LINK_O.in_dir_active  = q_r.in_split || q_r.in_dir;
    assign LINK_O.out_dir_active = q_r.in_split || !q_r.in_dir;
    assign LINK_O.fifo_split     = q_r.in_split;
    assign LINK_O.periodic_in    = q_r.in_iso;
    assign LINK_O.periodic_out   = q_r.out_iso;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_in_empty_flag: assert property ((q_r.in_slots == 2'h0) |-> !LINK_O.in_pkt_avail)
        else $error("IN packet offered with empty FIFO");

    a_in_tx_clear: assert property ((LINK_I.in_tx_done && q_r.in_slots != 2'h0) |=> !q_r.in_prdy)
        else $error("IN ready not cleared after transmit");

    a_in_tx_int: assert property ((LINK_I.in_tx_done && q_r.in_slots != 2'h0 && q_r.in_int_en) |=> IN_INT_O)
        else $error("IN interrupt missing after transmit");

    a_iso_wait_hold: assert property ((q_r.in_iso_wait && !LINK_I.sof) |=> !LINK_O.in_pkt_avail)
        else $error("IN packet offered before SOF in underrun mode");

    a_force_toggle: assert property ((LINK_I.in_tx_done && q_r.in_force && !wr_in_low)
        |=> q_r.in_toggle != $past(q_r.in_toggle))
        else $error("Forced toggle did not switch");

    a_stall_reply: assert property ((LINK_I.out_pkt && !q_r.out_iso && q_r.out_send_stall)
        |=> q_r.hs_stall && q_r.out_stall_sent)
        else $error("STALL not answered or not flagged");

    a_stall_int: assert property ((LINK_I.out_pkt && !q_r.out_iso && q_r.out_send_stall && q_r.out_int_en)
        |=> OUT_INT_O)
        else $error("STALL interrupt missing");

    a_opr_reload: assert property ((out_pop && q_r.out_slots == 2'h2 && q_r.out_opr)
        |=> !q_r.out_opr ##1 (q_r.out_opr && OUT_INT_O == q_r.out_int_en))
        else $error("Second OUT packet not presented after release");

    a_iso_overrun: assert property ((LINK_I.out_pkt && q_r.out_iso && q_r.out_slots == out_cap && !out_pop)
        |=> q_r.out_overrun)
        else $error("Overrun flag not set");

    a_high_unused: assert property ((req && !q_r.wb_ack && !WE_I && idx == uepc_pkg::IDX_IN_CTL_HIGH)
        |=> ACK_O && DAT_O[1:0] == 2'h0 && DAT_O[4] == 1'b0)
        else $error("Unused IN high bits read nonzero");

    // Config writes land on the acknowledged edge, visible one cycle on
    a_in_dbl_write: assert property (wr_in_high
        |=> q_r.in_dbl == $past(wd[uepc_pkg::B_IN_DBL]))
        else $error("IN double buffer setting not taken");

    a_iso_in_select: assert property (wr_in_high
        |=> LINK_O.periodic_in == $past(wd[uepc_pkg::B_IN_ISO]))
        else $error("IN isochronous setting not taken");

    a_dir_select: assert property ((wr_in_high && !wd[uepc_pkg::B_IN_SPLIT])
        |=> LINK_O.in_dir_active == $past(wd[uepc_pkg::B_IN_DIR]) && LINK_O.out_dir_active != $past(wd[uepc_pkg::B_IN_DIR]))
        else $error("Direction select not applied");

    a_split_halves: assert property ((wr_in_high && wd[uepc_pkg::B_IN_SPLIT])
        |=> LINK_O.fifo_split && LINK_O.in_dir_active && LINK_O.out_dir_active)
        else $error("Split FIFO does not serve both directions");

    a_out_iso_select: assert property (wr_out_high
        |=> LINK_O.periodic_out == $past(wd[uepc_pkg::B_OUT_ISO]))
        else $error("OUT isochronous setting not taken");

    a_in_dbl_release: assert property ((q_r.in_dbl && q_r.in_prdy && q_r.in_slots < uepc_pkg::SLOTS_DOUBLE)
        |=> !q_r.in_prdy)
        else $error("IN ready held with a free slot");

    a_ud_read_zero: assert property ((q_r.in_iso_wait && req && !q_r.wb_ack && !WE_I)
        && idx == uepc_pkg::IDX_IN_CTL_LOW |=> !DAT_O[uepc_pkg::B_IN_PRDY])
        else $error("IN ready read high while waiting for SOF");

    // Empty-slot cases only, so a full FIFO cannot turn the ACK into a NAK
    a_bulk_ready: assert property ((LINK_I.out_pkt && !q_r.out_iso && !q_r.out_send_stall)
        && !LINK_I.out_crc_err && q_r.out_slots == 2'h0 |=> q_r.hs_ack ##1 q_r.out_opr)
        else $error("Bulk OUT packet not acknowledged and presented");

    a_count_capture: assert property ((LINK_I.out_pkt && q_r.out_slots == 2'h0 && !q_r.out_send_stall)
        && !LINK_I.out_crc_err |=> q_r.out_cnt0 == $past(LINK_I.out_bytes))
        else $error("OUT byte count not captured");

    a_ready_int: assert property ((!q_r.out_opr && q_r.out_slots != 2'h0 && !out_pop)
        && q_r.out_int_en |=> q_r.out_opr && OUT_INT_O)
        else $error("OUT ready set without interrupt");

    a_stall_flag_hold: assert property (q_r.out_stall_sent
        && !(wr_out_low && !wd[uepc_pkg::B_OUT_STL_SENT]) |=> q_r.out_stall_sent)
        else $error("Stall sent flag lost without firmware clear");

    a_crc_iso_load: assert property ((LINK_I.out_pkt && q_r.out_iso && LINK_I.out_crc_err)
        && q_r.out_slots == 2'h0 |=> q_r.out_crc_err && q_r.out_slots != 2'h0)
        else $error("Isochronous CRC packet not loaded and flagged");

    a_out_clr_toggle: assert property ((wr_out_low && wd[uepc_pkg::B_OUT_CLR_TOG] && !LINK_I.out_pkt)
        |=> !LINK_O.out_toggle)
        else $error("OUT toggle not cleared");

    c_out_reload: cover property (out_pop && q_r.out_slots == 2'h2);
    c_stall_sent: cover property (q_r.hs_stall);
    c_iso_overrun: cover property (LINK_I.out_pkt && q_r.out_iso && !out_room);
    c_in_double: cover property (q_r.in_slots == 2'h2);
    c_iso_crc: cover property (LINK_I.out_pkt && q_r.out_iso && LINK_I.out_crc_err);

endmodule

`default_nettype wire

// ==== uepc_pkg.sv ====
// Constants, register indices and carrier types for the endpoint control block
package uepc_pkg;

    // Width of the OUT packet byte count
    localparam int          UEPC_CNT_W       = 11;

    // Register indices; byte address on the bus is four times the index
    localparam logic [5:0]  IDX_IN_CTL_LOW   = 6'h11;
    localparam logic [5:0]  IDX_IN_CTL_HIGH  = 6'h12;
    localparam logic [5:0]  IDX_OUT_CTL_LOW  = 6'h14;
    localparam logic [5:0]  IDX_OUT_CTL_HIGH = 6'h15;
    localparam logic [5:0]  IDX_OUT_CNT_LOW  = 6'h16;
    localparam logic [5:0]  IDX_OUT_CNT_HIGH = 6'h17;
    localparam logic [5:0]  IDX_EP_MODE      = 6'h18;

    // in_endpoint_control_low fields
    localparam int          B_IN_PRDY        = 0;
    localparam int          B_IN_HAS_PKT     = 1;
    localparam int          B_IN_FLUSH       = 3;
    localparam int          B_IN_CLR_TOG     = 6;
    // in_endpoint_control_high fields
    localparam int          B_IN_DBL         = 7;
    localparam int          B_IN_ISO         = 6;
    localparam int          B_IN_DIR         = 5;
    localparam int          B_IN_FORCE       = 3;
    localparam int          B_IN_SPLIT       = 2;
    // out_endpoint_control_low fields
    localparam int          B_OUT_OPR        = 0;
    localparam int          B_OUT_FULL       = 1;
    localparam int          B_OUT_OVR        = 2;
    localparam int          B_OUT_CRC        = 3;
    localparam int          B_OUT_FLUSH      = 4;
    localparam int          B_OUT_SEND_STL   = 5;
    localparam int          B_OUT_STL_SENT   = 6;
    localparam int          B_OUT_CLR_TOG    = 7;
    // out_endpoint_control_high fields
    localparam int          B_OUT_DBL        = 7;
    localparam int          B_OUT_ISO        = 6;
    // Endpoint mode register fields
    localparam int          B_IN_INT_EN      = 0;
    localparam int          B_OUT_INT_EN     = 1;
    localparam int          B_IN_UNDERRUN    = 2;

    // Packet slot limits
    localparam logic [1:0]  SLOTS_SINGLE     = 2'h1;
    localparam logic [1:0]  SLOTS_DOUBLE     = 2'h2;

    // Events from the packet engine
    typedef struct packed {
        logic                  sof;
        logic                  in_tx_done;
        logic                  in_ack;
        logic                  out_pkt;
        logic                  out_crc_err;
        logic [UEPC_CNT_W-1:0] out_bytes;
    } uepc_link_in_s;

    // Status and handshake decisions to the packet engine
    typedef struct packed {
        logic                  in_pkt_avail;
        logic                  in_toggle;
        logic                  out_toggle;
        logic                  out_ack;
        logic                  out_nak;
        logic                  out_stall;
        logic                  in_dir_active;
        logic                  out_dir_active;
        logic                  fifo_split;
        logic                  periodic_in;
        logic                  periodic_out;
    } uepc_link_out_s;

    // Whole state of the block
    typedef struct packed {
        logic                  wb_ack;
        logic [7:0]            wb_dat;
        logic                  in_dbl;
        logic                  in_iso;
        logic                  in_dir;
        logic                  in_force;
        logic                  in_split;
        logic                  in_ud;
        logic                  in_prdy;
        logic                  in_iso_wait;
        logic [1:0]            in_slots;
        logic                  in_toggle;
        logic                  out_dbl;
        logic                  out_iso;
        logic                  out_send_stall;
        logic                  out_stall_sent;
        logic                  out_crc_err;
        logic                  out_overrun;
        logic                  out_opr;
        logic [1:0]            out_slots;
        logic                  out_toggle;
        logic [UEPC_CNT_W-1:0] out_cnt0;
        logic [UEPC_CNT_W-1:0] out_cnt1;
        logic                  hs_ack;
        logic                  hs_nak;
        logic                  hs_stall;
        logic                  in_int;
        logic                  out_int;
        logic                  in_int_en;
        logic                  out_int_en;
    } uepc_state_s;

    localparam uepc_state_s UEPC_STATE_RST = '0;

endpackage

// ==== uepc_host_model.sv ====
// Host-side token and packet driver for the endpoint block
`timescale 1ns/1ns
`default_nettype none
module uepc_host_model (
    input  wire logic               clk_i,
    input  wire uepc_pkg::uepc_link_out_s link_i,
    output var uepc_pkg::uepc_link_in_s   link_o
);
    initial link_o = '0;
    // Qualifiers go to the inverse outside a packet, never a stale copy
    task automatic out_pkt(input logic [10:0] n, input logic crc, output logic [2:0] hs);
        @(posedge clk_i);
        link_o.out_pkt     <= 1'b1;
        link_o.out_bytes   <= n;
        link_o.out_crc_err <= crc;
        @(posedge clk_i);
        link_o.out_pkt     <= 1'b0;
        link_o.out_bytes   <= ~n;
        link_o.out_crc_err <= ~crc;
        @(negedge clk_i);
        hs = {link_i.out_ack, link_i.out_nak, link_i.out_stall};
    endtask
    task automatic in_done(input logic ack);
        @(posedge clk_i);
        link_o.in_tx_done <= 1'b1;
        link_o.in_ack     <= ack;
        @(posedge clk_i);
        link_o.in_tx_done <= 1'b0;
        link_o.in_ack     <= 1'b0;
    endtask
    task automatic sof();
        @(posedge clk_i);
        link_o.sof <= 1'b1;
        @(posedge clk_i);
        link_o.sof <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== test_usb_endpoint_in_out_control.sv ====
// Self-checking bench for the endpoint control block
`timescale 1ns/1ns
`default_nettype none
module test_usb_endpoint_in_out_control;
    logic                     CLK_I = 0, RST_I = 1, CYC_I = 0, STB_I = 0, WE_I = 0;
    logic [7:0]               ADR_I = 8'h00;
    logic [3:0]               SEL_I = 4'h0;
    logic [31:0]              DAT_I = 32'h0, DAT_O;
    logic                     ACK_O, IN_INT_O, OUT_INT_O;
    uepc_pkg::uepc_link_in_s  LINK_I;
    uepc_pkg::uepc_link_out_s LINK_O;
    logic [31:0]              exp_q[$];
    int                       fails = 0, n_compared = 0, cyc_n = 0, n_in = 0, n_out = 0;
    logic [7:0]               r;
    logic [10:0]              b1, b2;
    logic [2:0]               hs;

    always #4 CLK_I = ~CLK_I;
    uepc_endpoint uepc_endpoint_inst (.CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .LINK_I(LINK_I), .LINK_O(LINK_O), .IN_INT_O(IN_INT_O), .OUT_INT_O(OUT_INT_O));
    uepc_host_model uepc_host_model_inst (.clk_i(CLK_I), .link_i(LINK_O), .link_o(LINK_I));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Held until ack is seen in its cycle, released after the sampling edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        {CYC_I, STB_I, WE_I, SEL_I} <= {2'b11, we, 4'hf};
        ADR_I <= a;
        DAT_I <= {24'h0, d};
        do @(posedge CLK_I); while (ACK_O !== 1'b1);
        {CYC_I, STB_I} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        wb(1'b0, a, 8'h00);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge CLK_I);
    endtask

    // Watcher: read data against the oldest note, interrupt pulses, timeout
    always @(negedge CLK_I) begin
        n_in += int'(IN_INT_O === 1'b1);
        n_out += int'(OUT_INT_O === 1'b1);
        if (ACK_O === 1'b1 && WE_I === 1'b0) check("read data", DAT_O, exp_q.pop_front());
        cyc_n++;
        if (cyc_n == 20000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(43));
        repeat (4) @(posedge CLK_I);
        RST_I <= 1'b0;
        rd(8'h48, 8'h00);
        rd(8'h50, 8'h00);
        rd(8'h00, 8'h00);
        repeat (4) begin
            r = 8'($urandom);
            wr(8'h48, r);
            rd(8'h48, r & 8'hec);
            settle(1);
            check("link cfg", 32'({LINK_O.fifo_split, LINK_O.periodic_in, LINK_O.in_dir_active,
                LINK_O.out_dir_active}), 32'({r[2], r[6], r[2] | r[5], r[2] | ~r[5]}));
        end
        wr(8'h60, 8'h03);
        wr(8'h48, 8'h00);
        wr(8'h44, 8'h01);
        rd(8'h44, 8'h03);
        uepc_host_model_inst.in_done(1'b1);
        settle(3);
        check("in int", n_in, 1);
        rd(8'h44, 8'h00);
        // Without ack the toggle holds unless forced
        for (int f = 0; f < 2; f++) begin
            wr(8'h48, f ? 8'h08 : 8'h00);
            wr(8'h44, 8'h01);
            uepc_host_model_inst.in_done(1'b0);
            settle(2);
            check("in toggle", 32'(LINK_O.in_toggle), 32'(f == 0));
        end
        wr(8'h48, 8'h80);
        wr(8'h44, 8'h01);
        rd(8'h44, 8'h02);
        uepc_host_model_inst.in_done(1'b0);
        settle(3);
        check("in int", n_in, 4);
        wr(8'h60, 8'h07);
        wr(8'h48, 8'h40);
        wr(8'h44, 8'h01);
        settle(1);
        check("in avail", 32'(LINK_O.in_pkt_avail), 0);
        uepc_host_model_inst.sof();
        settle(2);
        check("in avail", 32'(LINK_O.in_pkt_avail), 1);
        uepc_host_model_inst.in_done(1'b1);
        wr(8'h54, 8'h00);
        b1 = 11'($urandom);
        b2 = 11'($urandom);
        n_out = 0;
        uepc_host_model_inst.out_pkt(b1, 1'b0, hs);
        check("handshake", 32'(hs), 32'h4);
        rd(8'h50, 8'h03);
        rd(8'h58, b1[7:0]);
        rd(8'h5c, {5'h0, b1[10:8]});
        check("out int", n_out, 1);
        wr(8'h50, 8'h00);
        rd(8'h50, 8'h00);
        check("out toggle", 32'(LINK_O.out_toggle), 1);
        wr(8'h50, 8'h80);
        rd(8'h50, 8'h00);
        check("out toggle", 32'(LINK_O.out_toggle), 0);
        wr(8'h54, 8'h80);
        uepc_host_model_inst.out_pkt(b1, 1'b0, hs);
        uepc_host_model_inst.out_pkt(b2, 1'b0, hs);
        rd(8'h58, b1[7:0]);
        wr(8'h50, 8'h00);
        rd(8'h50, 8'h01);
        rd(8'h58, b2[7:0]);
        wr(8'h50, 8'h00);
        check("out int", n_out, 3);
        wr(8'h54, 8'h00);
        wr(8'h50, 8'h20);
        uepc_host_model_inst.out_pkt(b1, 1'b0, hs);
        check("handshake", 32'(hs), 32'h1);
        rd(8'h50, 8'h60);
        wr(8'h50, 8'h20);
        rd(8'h50, 8'h20);
        wr(8'h50, 8'h00);
        check("out int", n_out, 4);
        wr(8'h54, 8'h40);
        uepc_host_model_inst.out_pkt(b1, 1'b1, hs);
        uepc_host_model_inst.out_pkt(b2, 1'b0, hs);
        check("handshake", 32'(hs), 32'h0);
        rd(8'h50, 8'h0f);
        wr(8'h50, 8'h00);
        rd(8'h50, 8'h00);
        check("out int", n_out, 6);
        wr(8'h54, 8'hc0);
        uepc_host_model_inst.out_pkt(b1, 1'b0, hs);
        uepc_host_model_inst.out_pkt(b2, 1'b0, hs);
        rd(8'h50, 8'h03);
        wr(8'h50, 8'h00);
        rd(8'h58, b2[7:0]);
        wr(8'h50, 8'h00);
        check("out int", n_out, 8);
        settle(4);
        end_of_test();
    end
endmodule
`default_nettype wire
